// File: rtl/slpc_defines.svh
/*
  Constants for the sleep controller: mode codes, control bit reset values
  and wake-up timing counts. Assumes a 100 MHz system clock.
*/
`ifndef SLPC_DEFINES_SVH
`define SLPC_DEFINES_SVH

`define SLPC_MODE_IDLE 3'h0
`define SLPC_MODE_ADCNR 3'h1
`define SLPC_MODE_PDOWN 3'h2
`define SLPC_MODE_PSAVE 3'h3
`define SLPC_MODE_STBY 3'h6
`define SLPC_MODE_XSTBY 3'h7
`define SLPC_BROWNOUT_SLEEP_OFF_RST 1'h0
`define SLPC_CLK_NS 10
`define SLPC_HALT_EXTRA 4
`define SLPC_STBY_WAKE 6
`define SLPC_BOD_WAKE_NS 60000
`define SLPC_BOD_WAKE_CYC (`SLPC_BOD_WAKE_NS / `SLPC_CLK_NS)
`define SLPC_TIMED_WIN 4

`endif

// File: rtl/slpc_pkg.sv
/*
  Types for the sleep controller. Assumes slpc_defines.svh for numbers.
*/
package slpc_pkg;
  typedef enum logic [1:0] {
    SLPC_RUN,
    SLPC_SLEEP,
    SLPC_WAKE
  } slpc_state_t;

  // Clock domain gates, 1 = clock running
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic osc;
  } slpc_clk_t;

  // Wake event sources
  typedef struct packed {
    logic ext0;
    logic ext1;
    logic pin_chg;
    logic twi_match;
    logic tmr2;
    logic spm_rdy;
    logic adc_done;
    logic wdt_irq;
    logic other_io;
  } slpc_wake_t;
endpackage : slpc_pkg

// File: rtl/slpc_sleep_ctrl.sv
/*
  Sleep mode controller: gates clock domains per mode, qualifies wake
  events, times the wake-up delay and handles software brown-out disable.
  Assumes the core pulses sleep_instr and presents enabled irq levels.
*/
// What this block does
// RULE1 - Sleep only with enable set plus instruction
// RULE2 - Idle stops only CPU and flash clocks
// RULE3 - Idle wakes on any enabled interrupt
// RULE4 - ADC noise mode stops IO, CPU, flash
// RULE5 - Timer2 runs there only when asynchronous
// RULE6 - ADC conversion starts on noise mode entry
// RULE7 - Noise mode wakes only on listed events
// RULE8 - Halt start-up plus four cycles after wake
// RULE9 - Register file and SRAM kept unchanged
// RULE10 - Reset during sleep restarts at vector
// RULE11 - Async clock and oscillator per mode table
// RULE12 - Outside idle, external irqs wake level only
// RULE13 - Brown-out sleep bit turns monitor off
// RULE14 - Software disable only in deep modes
// RULE15 - Monitor re-enabled on every wake
// RULE16 - Wake delay about 60 us after disable
// RULE17 - Brown-out sleep bit needs timed sequence
// RULE18 - Standby advised only with crystal clock
// RULE19 - Power-down stops all generated clocks
// RULE20 - Power-save keeps timer2 for wake
// RULE21 - Standby modes keep oscillator, wake six
// RULE22 - Codes 100, 101 enter no sleep
`include "slpc_defines.svh"

module slpc_sleep_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Core control
  input wire logic sleep_enable_bit,
  input wire logic [2:0] sleep_select_field,
  input wire logic sleep_instr,
  input wire logic brownout_sleep_off_enable_wr,
  input wire logic brownout_sleep_off_wr,
  input wire logic brownout_sleep_off_wr_val,
  // Wake sources and configuration
  input wire slpc_pkg::slpc_wake_t wake_in,
  input wire logic ext0_level,
  input wire logic ext1_level,
  input wire logic tmr2_async,
  input wire logic adc_enabled,
  input wire logic [15:0] startup_cycles,
  // Outputs
  output slpc_pkg::slpc_clk_t clk_gate,
  output logic tmr2_clk_en,
  output logic adc_start,
  output logic brownout_monitor_en,
  output logic brownout_sleep_off,
  output logic cpu_halt,
  output logic irq_resume,
  output logic [2:0] active_mode
);
  import slpc_pkg::*;

  slpc_state_t state_q, state_d;
  logic [2:0] mode_q, mode_d;
  logic [15:0] cnt_q, cnt_d;
  logic brownout_sleep_off_q, brownout_sleep_off_d;
  logic [2:0] win_q, win_d;
  logic bod_off_q, bod_off_d;
  slpc_clk_t clk_gate_q, clk_gate_d;
  logic tmr2_q, tmr2_d, adc_start_q, adc_start_d, resume_q, resume_d;
  logic wake_ok;
  logic mode_valid, deep_mode;
  logic halt_q, halt_d, bod_en_q, bod_en_d;

  // Mode decode
  always_comb begin
    // RULE22 reserved codes
    mode_valid = (sleep_select_field != 3'h4) && (sleep_select_field != 3'h5);
    // RULE14 deep modes only
    deep_mode = (sleep_select_field == `SLPC_MODE_PDOWN) ||
                (sleep_select_field == `SLPC_MODE_PSAVE) ||
                (sleep_select_field == `SLPC_MODE_STBY) ||
                (sleep_select_field == `SLPC_MODE_XSTBY);
  end

  // Wake qualification per current mode
  always_comb begin
    logic ext_any;
    ext_any = 1'b0;
    wake_ok = 1'b0;
    // RULE12 level-only external irq
    ext_any = (wake_in.ext0 && ext0_level) || (wake_in.ext1 && ext1_level) ||
              wake_in.pin_chg;
    case (mode_q)
      // RULE3 any enabled irq
      `SLPC_MODE_IDLE: wake_ok = |wake_in;
      // RULE7 restricted event set
      `SLPC_MODE_ADCNR: wake_ok = ext_any || wake_in.twi_match ||
        (wake_in.tmr2 && tmr2_async) || wake_in.spm_rdy ||
        wake_in.adc_done || wake_in.wdt_irq;
      // RULE20 timer2 wake in save modes
      `SLPC_MODE_PSAVE, `SLPC_MODE_XSTBY: wake_ok = ext_any ||
        wake_in.twi_match || wake_in.tmr2 || wake_in.wdt_irq;
      // RULE19 power-down and standby set
      default: wake_ok = ext_any || wake_in.twi_match || wake_in.wdt_irq;
    endcase
  end

  // Brown-out sleep bit, timed write
  always_comb begin
    brownout_sleep_off_d = brownout_sleep_off_q;
    win_d = (win_q != 3'h0) ? win_q - 3'h1 : 3'h0;
    // RULE15 bit consumed by sleep
    if (state_q == SLPC_WAKE && state_d == SLPC_RUN) begin
      brownout_sleep_off_d = 1'b0;
    end
    // RULE17 enable opens window
    // A write in the resume cycle wins over the clear
    if (brownout_sleep_off_enable_wr) begin
      win_d = 3'(`SLPC_TIMED_WIN);
    end else if (brownout_sleep_off_wr && win_q != 3'h0) begin
      brownout_sleep_off_d = brownout_sleep_off_wr_val;
      win_d = 3'h0;
    end
  end

  // Sleep sequencer
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    bod_off_d = bod_off_q;
    adc_start_d = 1'b0;
    resume_d = 1'b0;
    case (state_q)
      SLPC_RUN: begin
        // RULE1 both conditions
        if (sleep_instr && sleep_enable_bit && mode_valid) begin
          state_d = SLPC_SLEEP;
          mode_d = sleep_select_field;
          // RULE13 monitor off
          bod_off_d = brownout_sleep_off_q && deep_mode;
          // RULE6 auto conversion
          adc_start_d = (sleep_select_field == `SLPC_MODE_ADCNR) &&
                        adc_enabled;
        end
      end
      SLPC_SLEEP: begin
        if (wake_ok) begin
          state_d = SLPC_WAKE;
          // RULE15 monitor back on
          bod_off_d = 1'b0;
          // RULE16 extended delay
          if (bod_off_q) begin
            cnt_d = 16'(`SLPC_BOD_WAKE_CYC + `SLPC_HALT_EXTRA);
          // RULE21 six-cycle wake
          end else if (mode_q == `SLPC_MODE_STBY ||
                       mode_q == `SLPC_MODE_XSTBY) begin
            cnt_d = 16'(`SLPC_STBY_WAKE + `SLPC_HALT_EXTRA);
          // RULE8 start-up plus four
          end else begin
            cnt_d = startup_cycles + 16'(`SLPC_HALT_EXTRA);
          end
        end
      end
      SLPC_WAKE: begin
        if (cnt_q <= 16'h1) begin
          state_d = SLPC_RUN;
          resume_d = 1'b1;
          cnt_d = 16'h0;
        end else begin
          cnt_d = cnt_q - 16'h1;
        end
      end
      default: state_d = SLPC_RUN;
    endcase
    // Monitor enable registered from next value
    bod_en_d = !bod_off_d;
  end

  // Clock gating per mode
  always_comb begin
    clk_gate_d = '1;
    tmr2_d = 1'b1;
    if (state_d != SLPC_RUN) begin
      clk_gate_d.cpu = 1'b0;
      clk_gate_d.flash = 1'b0;
      case (mode_d)
        // RULE2 idle gating
        `SLPC_MODE_IDLE: ;
        // RULE4 noise mode gating
        `SLPC_MODE_ADCNR: begin
          clk_gate_d.io = 1'b0;
          // RULE5 sync timer2 frozen
          tmr2_d = tmr2_async;
        end
        // RULE11 async and osc per mode
        `SLPC_MODE_PSAVE, `SLPC_MODE_XSTBY: begin
          clk_gate_d.io = 1'b0;
          clk_gate_d.adc = 1'b0;
          clk_gate_d.osc = (mode_d == `SLPC_MODE_XSTBY);
          tmr2_d = tmr2_async;
        end
        default: begin
          clk_gate_d.io = 1'b0;
          clk_gate_d.adc = 1'b0;
          clk_gate_d.asy = 1'b0;
          clk_gate_d.osc = (mode_d == `SLPC_MODE_STBY);
          tmr2_d = 1'b0;
        end
      endcase
    end
    // Halt flag mirrors the CPU gate
    halt_d = !clk_gate_d.cpu;
  end

  // State registers; RULE10 reset returns to run and vector
  // RULE9 no storage touched, only clocks gated
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SLPC_RUN;
      mode_q <= `SLPC_MODE_IDLE;
      cnt_q <= 16'h0;
      brownout_sleep_off_q <= `SLPC_BROWNOUT_SLEEP_OFF_RST;
      win_q <= 3'h0;
      bod_off_q <= 1'b0;
      clk_gate_q <= '1;
      tmr2_q <= 1'b1;
      adc_start_q <= 1'b0;
      resume_q <= 1'b0;
      halt_q <= 1'b0;
      bod_en_q <= 1'b1;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      brownout_sleep_off_q <= brownout_sleep_off_d;
      win_q <= win_d;
      bod_off_q <= bod_off_d;
      clk_gate_q <= clk_gate_d;
      tmr2_q <= tmr2_d;
      adc_start_q <= adc_start_d;
      resume_q <= resume_d;
      halt_q <= halt_d;
      bod_en_q <= bod_en_d;
    end
  end

  assign clk_gate = clk_gate_q;
  assign tmr2_clk_en = tmr2_q;
  assign adc_start = adc_start_q;
  assign brownout_monitor_en = bod_en_q;
  assign brownout_sleep_off = brownout_sleep_off_q;
  assign cpu_halt = halt_q;
  assign irq_resume = resume_q;
  assign active_mode = mode_q;

  // Assertions
  property p_enter;
    @(posedge clk) disable iff (!rstn)
    (state_q == SLPC_RUN && !(sleep_instr && sleep_enable_bit)) |=>
      state_q != SLPC_SLEEP;
  endproperty
  a_enter: assert property (p_enter) else $error("sleep without enable"); // RULE1

  property p_idle;
    @(posedge clk) disable iff (!rstn)
    (state_q == SLPC_SLEEP && mode_q == `SLPC_MODE_IDLE) |->
      clk_gate_q.io && clk_gate_q.adc && !clk_gate_q.cpu;
  endproperty
  a_idle: assert property (p_idle) else $error("idle gating wrong"); // RULE2

  property p_adcnr;
    @(posedge clk) disable iff (!rstn)
    (state_q == SLPC_SLEEP && mode_q == `SLPC_MODE_ADCNR) |->
      !clk_gate_q.io && clk_gate_q.adc && clk_gate_q.asy;
  endproperty
  a_adcnr: assert property (p_adcnr) else $error("noise gating wrong"); // RULE4

  property p_adcstart;
    @(posedge clk) disable iff (!rstn)
    (state_q == SLPC_RUN && sleep_instr && sleep_enable_bit &&
     sleep_select_field == `SLPC_MODE_ADCNR && adc_enabled) |=> adc_start;
  endproperty
  a_adcstart: assert property (p_adcstart) else $error("no adc start"); // RULE6

  property p_edge;
    @(posedge clk) disable iff (!rstn)
    (state_q == SLPC_SLEEP && mode_q == `SLPC_MODE_PDOWN &&
     wake_in == 9'h100 && !ext0_level) |=> state_q == SLPC_SLEEP;
  endproperty
  a_edge: assert property (p_edge) else $error("edge irq woke"); // RULE12

  property p_stby;
    @(posedge clk) disable iff (!rstn)
    (state_q == SLPC_SLEEP && mode_q == `SLPC_MODE_STBY && !bod_off_q &&
     wake_ok) |=> (state_q == SLPC_WAKE) [*5] ##1
      (state_q == SLPC_WAKE) [*5] ##1 (state_q == SLPC_RUN);
  endproperty
  a_stby: assert property (p_stby) else $error("standby wake time"); // RULE21

  property p_bodon;
    @(posedge clk) disable iff (!rstn)
    state_q == SLPC_WAKE |-> brownout_monitor_en;
  endproperty
  a_bodon: assert property (p_bodon) else $error("bod still off"); // RULE15

  property p_bodkeep;
    @(posedge clk) disable iff (!rstn)
    (mode_q == `SLPC_MODE_IDLE || mode_q == `SLPC_MODE_ADCNR) |->
      brownout_monitor_en;
  endproperty
  a_bodkeep: assert property (p_bodkeep) else $error("bod off shallow"); // RULE14

  property p_resv;
    @(posedge clk) disable iff (!rstn)
    (state_q == SLPC_RUN && sleep_select_field[2:1] == 2'b10) |=>
      state_q == SLPC_RUN;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved entered"); // RULE22

  c_idle: cover property (@(posedge clk) disable iff (!rstn)
    state_q == SLPC_SLEEP && mode_q == `SLPC_MODE_IDLE ##1
    state_q == SLPC_WAKE);
  c_adcnr: cover property (@(posedge clk) disable iff (!rstn)
    adc_start);
  c_bod: cover property (@(posedge clk) disable iff (!rstn)
    !brownout_monitor_en ##1 brownout_monitor_en);
endmodule : slpc_sleep_ctrl

// File: testbench/slpc_core_model.sv
/*
  Core-side model: issues sleep instruction pulses and the timed
  brown-out sleep bit write. Assumes the clock of tb_top.
*/
module slpc_core_model (
  // Clock
  input wire logic clk,
  // Requests to the controller
  output logic sleep_instr,
  output logic brownout_sleep_off_enable_wr,
  output logic brownout_sleep_off_wr,
  output logic brownout_sleep_off_wr_val
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet levels at time zero
  initial begin
    sleep_instr = 1'h0;
    brownout_sleep_off_enable_wr = 1'h0;
    brownout_sleep_off_wr = 1'h0;
    brownout_sleep_off_wr_val = 1'h0;
  end

  // standby callers run from a crystal
  task sleep_op;
    @(posedge clk);
    #1 sleep_instr = 1'h1;
    @(posedge clk);
    #1 sleep_instr = 1'h0;
  endtask : sleep_op

  task brownout_sleep_off_seq(input logic v, input logic timed);
    @(posedge clk);
    #1 brownout_sleep_off_enable_wr = timed;
    @(posedge clk);
    #1 brownout_sleep_off_enable_wr = 1'h0;
    brownout_sleep_off_wr = 1'h1;
    brownout_sleep_off_wr_val = v;
    @(posedge clk);
    #1 brownout_sleep_off_wr = 1'h0;
    brownout_sleep_off_wr_val = ~v; // Released value not held
  endtask : brownout_sleep_off_seq
endmodule : slpc_core_model

// File: testbench/tb_top.sv
/*
  Self-checking bench for the sleep controller: mode table, wake
  qualification, brown-out disable and reset in sleep.
  Assumes slpc_sleep_ctrl and slpc_core_model.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import slpc_pkg::*;

  typedef struct packed {
    logic [2:0] m;
    logic [5:0] g;
    logic h;
    logic [3:0] n;
  } slpc_row_t;

  logic clk, rstn, sleep_enable_bit, sleep_instr;
  logic brownout_sleep_off_enable_wr, brownout_sleep_off_wr, brownout_sleep_off_wr_val;
  logic ext0_level, ext1_level, tmr2_async, adc_enabled;
  logic [2:0] sleep_select_field, active_mode;
  logic [15:0] startup_cycles;
  slpc_wake_t wake_in;
  slpc_clk_t clk_gate;
  logic tmr2_clk_en, adc_start, brownout_monitor_en;
  logic brownout_sleep_off, cpu_halt, irq_resume;
  int bad_count = 0;
  int checks_done = 0;

  slpc_row_t rows [8] = '{'{3'h0, 6'h0F, 1'h1, 4'h9},
    '{3'h1, 6'h07, 1'h1, 4'h9}, '{3'h2, 6'h00, 1'h1, 4'h9},
    '{3'h3, 6'h02, 1'h1, 4'h9}, '{3'h6, 6'h01, 1'h1, 4'hA},
    '{3'h7, 6'h03, 1'h1, 4'hA}, '{3'h4, 6'h3F, 1'h0, 4'h0},
    '{3'h5, 6'h3F, 1'h0, 4'h0}};

  slpc_sleep_ctrl dut_u (.clk(clk), .rstn(rstn),
    .sleep_enable_bit(sleep_enable_bit),
    .sleep_select_field(sleep_select_field), .sleep_instr(sleep_instr),
    .brownout_sleep_off_enable_wr(brownout_sleep_off_enable_wr), .brownout_sleep_off_wr(brownout_sleep_off_wr),
    .brownout_sleep_off_wr_val(brownout_sleep_off_wr_val), .wake_in(wake_in),
    .ext0_level(ext0_level), .ext1_level(ext1_level),
    .tmr2_async(tmr2_async), .adc_enabled(adc_enabled),
    .startup_cycles(startup_cycles), .clk_gate(clk_gate),
    .tmr2_clk_en(tmr2_clk_en), .adc_start(adc_start),
    .brownout_monitor_en(brownout_monitor_en),
    .brownout_sleep_off(brownout_sleep_off), .cpu_halt(cpu_halt),
    .irq_resume(irq_resume), .active_mode(active_mode));

  slpc_core_model core_u (.clk(clk), .sleep_instr(sleep_instr),
    .brownout_sleep_off_enable_wr(brownout_sleep_off_enable_wr), .brownout_sleep_off_wr(brownout_sleep_off_wr),
    .brownout_sleep_off_wr_val(brownout_sleep_off_wr_val));

  // Clock, 10 ns period
  always #5 clk = ~clk;

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Count halted cycles until resume
  task automatic wake_time(input int n);
    int c;
    c = 0;
    while (irq_resume !== 1'h1 && c < 7000) begin
      @(posedge clk);
      #1 c++;
    end
    chk(c >= n && c <= n + 3, 1'h1);
    wake_in = 9'h000;
    repeat (2) @(posedge clk);
    #1;
  endtask : wake_time

  // Sleep, then hold an unwanted wake for a while
  task automatic stay_asleep(input logic [8:0] w);
    core_u.sleep_op();
    wake_in = w;
    repeat (20) @(posedge clk);
    #1 chk(cpu_halt, 1'h1);
  endtask : stay_asleep

  task report_and_stop;
    $display("checks=%0d bad=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    sleep_enable_bit = 1'h1;
    sleep_select_field = 3'h0;
    wake_in = 9'h000;
    ext0_level = 1'h1;
    ext1_level = 1'h1;
    tmr2_async = 1'h1;
    adc_enabled = 1'h1;
    startup_cycles = 16'h0005;
    repeat (2) @(posedge clk);
    #1 rstn = 1'h1;
    chk(clk_gate, 6'h3F);
    chk(brownout_sleep_off, 1'h0);
    foreach (rows[i]) begin
      sleep_select_field = rows[i].m;
      core_u.sleep_op();
      chk(clk_gate, rows[i].g);
      chk(cpu_halt, rows[i].h);
      chk(adc_start, rows[i].m == 3'h1);
      if (rows[i].h) begin
        chk(active_mode, rows[i].m);
        wake_in = 9'h100;
        wake_time(rows[i].n);
      end
    end
    sleep_select_field = 3'h0;
    sleep_enable_bit = 1'h0;
    core_u.sleep_op();
    chk(cpu_halt, 1'h0);
    sleep_enable_bit = 1'h1;
    core_u.sleep_op();
    chk(cpu_halt, 1'h1);
    wake_in = 9'h001;
    wake_time(9);
    ext0_level = 1'h0;
    sleep_select_field = 3'h2;
    stay_asleep(9'h100);
    ext0_level = 1'h1;
    wake_time(9);
    tmr2_async = 1'h0;
    sleep_select_field = 3'h1;
    stay_asleep(9'h011);
    chk(tmr2_clk_en, 1'h0);
    wake_in = 9'h004;
    wake_time(9);
    core_u.brownout_sleep_off_seq(1'h1, 1'h0);
    chk(brownout_sleep_off, 1'h0);
    core_u.brownout_sleep_off_seq(1'h1, 1'h1);
    chk(brownout_sleep_off, 1'h1);
    sleep_select_field = 3'h0;
    core_u.sleep_op();
    chk(brownout_monitor_en, 1'h1);
    wake_in = 9'h001;
    wake_time(9);
    core_u.brownout_sleep_off_seq(1'h1, 1'h1);
    sleep_select_field = 3'h2;
    core_u.sleep_op();
    chk(brownout_monitor_en, 1'h0);
    wake_in = 9'h100;
    wake_time(6004);
    chk(brownout_monitor_en, 1'h1);
    chk(brownout_sleep_off, 1'h0);
    core_u.sleep_op();
    chk(cpu_halt, 1'h1);
    rstn = 1'h0;
    #3 chk(cpu_halt, 1'h0);
    chk(clk_gate, 6'h3F);
    repeat (2) @(posedge clk);
    #1 rstn = 1'h1;
    chk(irq_resume, 1'h0);
    report_and_stop();
  end

  // Watchdog on the whole run
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule : tb_top
